//--- hw/band_page_bank.sv
// Purpose: Two copies of the band-specific registers, one per frequency band
// Assumes: Index is already range-checked by the caller
// Notes:   Only the selected copy is written; the other keeps its value
`timescale 1ns/1ps
module band_page_bank #(
	parameter int N = 19
) (
	input  wire logic mclk, // System clock
	input  wire logic rst,  // Asynchronous reset, active high
	bank_if.bank      bp    // Bank port
);
	import opmode_pkg::*;

	logic [7:0] low_copy  [N];
	logic [7:0] high_copy [N];

	// ==========================================================
	// One register pair per index
	for (genvar i = 0; i < N; i++) begin : g_reg
		localparam logic [7:0] MASK     = band_write_mask(i);
		localparam logic [7:0] LOW_RST  = band_low_reset(i);
		localparam logic [7:0] HIGH_RST = band_high_reset(i);
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				low_copy[i]  <= LOW_RST;
				high_copy[i] <= HIGH_RST;
			end else if (bp.we && bp.idx == 5'(i)) begin
				if (bp.band_low) begin
					low_copy[i] <= (low_copy[i] & ~MASK) | (bp.wdata & MASK);
				end else begin
					high_copy[i] <= (high_copy[i] & ~MASK) | (bp.wdata & MASK);
				end
			end
		end

		// Writing one band never disturbs the same place in the other band
		a_band_retain: assert property (@(posedge mclk) disable iff (rst)
			(bp.we && bp.idx == 5'(i) && bp.band_low) |=> $stable(high_copy[i]))
			else $error("high band copy changed on a low band write");

		a_band_keep_low: assert property (@(posedge mclk) disable iff (rst)
			(bp.we && bp.idx == 5'(i) && !bp.band_low) |=> $stable(low_copy[i]))
			else $error("low band copy changed on a high band write");
	end

	// Read the copy picked by the band select
	always_comb begin
		bp.rdata = 8'h00;
		if (32'(bp.idx) < N) begin
			bp.rdata = bp.band_low ? low_copy[bp.idx] : high_copy[bp.idx];
		end
	end

endmodule

//--- hw/baseband_fifo_mem.sv
// Purpose: Storage for the baseband FIFO with registered read data
// Assumes: Read address is the next read pointer, so data is ready one cycle ahead
// Notes:   Same-cycle write to the read address is bypassed to avoid stale data
`timescale 1ns/1ps
module baseband_fifo_mem #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic mclk, // System clock
	input  wire logic rst,  // Asynchronous reset, active high
	fifo_if.mem       fp    // Memory port
);
	import opmode_pkg::*;

	logic [7:0] mem [DEPTH];

	// ==========================================================
	// Write port; contents need no reset since pointers define validity
	always_ff @(posedge mclk) begin
		if (fp.we) begin
			mem[fp.waddr] <= fp.wdata;
		end
	end

	// Registered read, always tracking the head entry
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fp.rdata <= DATA_RST;
		end else if (fp.we && fp.waddr == fp.raddr) begin
			fp.rdata <= fp.wdata;
		end else begin
			fp.rdata <= mem[fp.raddr];
		end
	end

endmodule

//--- hw/long_range_opmode_register_page.sv
// Purpose: FIFO data port, operating-mode register and page routing of the long-range modem
// Assumes: Register port strobes are one cycle, never together; read data one cycle later
// Notes:   Addresses outside this page are forwarded as registered pulses with a page flag
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module long_range_opmode_register_page #(
	parameter int FIFO_DEPTH = 256
) (
	input  wire logic                     mclk,                // System clock, 50 MHz
	input  wire logic                     rst,                 // Async reset, active high
	input  wire logic [6:0]               addr,                // Register address
	input  wire logic [7:0]               wdata,               // Write data
	input  wire logic                     wr,                  // Write strobe
	input  wire logic                     rd,                  // Read strobe
	output      logic [7:0]               rdata,               // Read data, cycle after rd
	output      logic                     modem_family_select, // 1 long range, 0 FSK/OOK
	output      logic                     shared_page_access,  // FSK page in shared range
	output      logic                     band_page_select,    // 1 low band, 0 high band
	output      opmode_pkg::device_state_e device_state,       // Requested device state
	output      logic                     state_change,        // Pulse: new state requested
	output      logic [7:0]               carrier_freq_high,   // Carrier word bits 23:16
	output      logic                     page_wr,             // Forwarded write pulse
	output      logic                     page_rd,             // Forwarded read pulse
	output      logic                     page_fsk,            // Forwarded access is FSK page
	output      logic [6:0]               page_addr,           // Forwarded address
	output      logic [7:0]               page_wdata           // Forwarded write data
);
	import opmode_pkg::*;

	localparam int PW = $clog2(FIFO_DEPTH);

	// ==========================================================
	// Address decode
	function automatic logic in_span(input logic [6:0] a, input logic [6:0] lo,
			input logic [6:0] hi);
		in_span = (a >= lo) && (a <= hi);
	endfunction

	logic op_wr;
	logic car_wr;
	logic is_sleep;
	logic band_hit;
	logic ext_hit;
	logic shared_hit;

	assign op_wr      = wr && addr == ADDR_OPMODE;
	assign car_wr     = wr && addr == ADDR_CARRIER_HIGH;
	assign is_sleep   = device_state == sleep_state;
	assign band_hit   = in_span(addr, ADDR_BAND_LO, ADDR_BAND_HI);
	assign shared_hit = in_span(addr, ADDR_SHARED_LO, ADDR_SHARED_HI);
	// Everything between the local registers and the band page, plus the top
	assign ext_hit    = in_span(addr, ADDR_EXT_LO, ADDR_EXT_HI) || addr > ADDR_BAND_HI;

	// ==========================================================
	// Operating-mode register
	// Family may only move while asleep, since both modems share the radio
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			modem_family_select <= FAMILY_RST;
		end else if (op_wr && is_sleep) begin
			modem_family_select <= wdata[FAMILY_BIT];
		end
	end

	// Shared page and band select are plain read-write bits
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			shared_page_access <= SHARED_RST;
			band_page_select   <= BAND_RST;
		end else if (op_wr) begin
			shared_page_access <= wdata[SHARED_BIT];
			band_page_select   <= wdata[BAND_BIT];
		end
	end

	// Device state takes effect on the write itself
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			device_state <= MODE_RST;
			state_change <= 1'b0;
		end else begin
			state_change <= op_wr;
			if (op_wr) begin
				device_state <= device_state_e'(wdata[MODE_MSB:0]);
			end
		end
	end

	// ==========================================================
	// Carrier frequency high byte
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			carrier_freq_high <= CARRIER_HIGH_RST;
		end else if (car_wr) begin
			carrier_freq_high <= wdata;
		end
	end

	// ==========================================================
	// Baseband FIFO control
	// Depth must be a power of two; the pointers wrap on their own
	fifo_if #(.AW(PW), .DW(8)) fif ();

	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0]   fifo_level;
	logic [PW-1:0] next_rd_ptr;
	logic          fifo_wr;
	logic          fifo_rd;

	// Full writes and empty reads are dropped rather than corrupting the pointers
	assign fifo_wr = wr && addr == ADDR_FIFO && !is_sleep
		&& fifo_level != (PW+1)'(FIFO_DEPTH);
	assign fifo_rd = rd && addr == ADDR_FIFO && !is_sleep && fifo_level != '0;

	always_comb begin
		next_rd_ptr = rd_ptr;
		if (is_sleep) begin
			next_rd_ptr = '0;
		end else if (fifo_rd) begin
			next_rd_ptr = rd_ptr + 1'b1;
		end
	end

	assign fif.we    = fifo_wr;
	assign fif.waddr = wr_ptr;
	assign fif.wdata = wdata;
	assign fif.raddr = next_rd_ptr;

	// Pointers and level; sleep flushes the whole FIFO
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_ptr     <= '0;
			rd_ptr     <= '0;
			fifo_level <= '0;
		end else if (is_sleep) begin
			wr_ptr     <= '0;
			rd_ptr     <= '0;
			fifo_level <= '0;
		end else begin
			rd_ptr <= next_rd_ptr;
			if (fifo_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (fifo_wr && !fifo_rd) begin
				fifo_level <= fifo_level + 1'b1;
			end else if (fifo_rd && !fifo_wr) begin
				fifo_level <= fifo_level - 1'b1;
			end
		end
	end

	baseband_fifo_mem #(
		.DEPTH (FIFO_DEPTH),
		.AW    (PW)
	) u_fifo_mem (
		.mclk (mclk),
		.rst  (rst),
		.fp   (fif.mem)
	);

	// ==========================================================
	// Band-specific register bank
	bank_if bif ();

	assign bif.band_low = band_page_select;
	assign bif.we       = wr && band_hit;
	assign bif.idx      = 5'(addr - ADDR_BAND_LO);
	assign bif.wdata    = wdata;

	band_page_bank #(
		.N (BAND_REGS)
	) u_band_bank (
		.mclk (mclk),
		.rst  (rst),
		.bp   (bif.bank)
	);

	// ==========================================================
	// Read data mux; reserved and forwarded addresses read zero
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = 8'h00;
		if (addr == ADDR_FIFO) begin
			next_rdata = fifo_rd ? fif.rdata : 8'h00;
		end else if (addr == ADDR_OPMODE) begin
			next_rdata = {modem_family_select, shared_page_access, 2'b00,
				band_page_select, device_state};
		end else if (addr == ADDR_CARRIER_HIGH) begin
			next_rdata = carrier_freq_high;
		end else if (band_hit) begin
			next_rdata = bif.rdata;
		end
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= DATA_RST;
		end else begin
			rdata <= rd ? next_rdata : 8'h00;
		end
	end

	// ==========================================================
	// Forwarding to the modem pages
	// The shared range follows the shared bit only while long range is active
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			page_wr    <= 1'b0;
			page_rd    <= 1'b0;
			page_fsk   <= 1'b1;
			page_addr  <= 7'h00;
			page_wdata <= 8'h00;
		end else begin
			page_wr <= wr && ext_hit;
			page_rd <= rd && ext_hit;
			if ((wr || rd) && ext_hit) begin
				page_addr  <= addr;
				page_wdata <= wdata;
				if (shared_hit) begin
					page_fsk <= !(modem_family_select && !shared_page_access);
				end else begin
					page_fsk <= !modem_family_select;
				end
			end
		end
	end

	// ==========================================================
	// Checks
	a_family_locked: assert property (@(posedge mclk) disable iff (rst)
		(op_wr && !is_sleep) |=> $stable(modem_family_select))
		else $error("family changed outside sleep");

	a_family_sleep_wr: assert property (@(posedge mclk) disable iff (rst)
		(op_wr && is_sleep) |=> modem_family_select == $past(wdata[FAMILY_BIT]))
		else $error("family not written in sleep");

	a_mode_immediate: assert property (@(posedge mclk) disable iff (rst)
		op_wr |=> (device_state == $past(wdata[MODE_MSB:0])) && state_change)
		else $error("state not taken on write");

	a_opmode_readback: assert property (@(posedge mclk) disable iff (rst)
		(rd && addr == ADDR_OPMODE) |=> (rdata[5:4] == 2'b00)
			&& (rdata[MODE_MSB:0] == $past(device_state))
			&& (rdata[BAND_BIT] == $past(band_page_select)))
		else $error("operating-mode readback wrong");

	a_sleep_flush: assert property (@(posedge mclk) disable iff (rst)
		is_sleep |=> fifo_level == '0)
		else $error("fifo not emptied in sleep");

	a_sleep_read_zero: assert property (@(posedge mclk) disable iff (rst)
		(rd && addr == ADDR_FIFO && is_sleep) |=> rdata == 8'h00 ##1 fifo_level == '0)
		else $error("fifo readable in sleep");

	a_fifo_order: assert property (@(posedge mclk) disable iff (rst)
		(fifo_level == '0 && fifo_wr && !is_sleep) ##1 (rd && addr == ADDR_FIFO && !is_sleep)
			|=> rdata == $past(wdata, 2))
		else $error("fifo data lost");

	a_carrier_write: assert property (@(posedge mclk) disable iff (rst)
		car_wr |=> carrier_freq_high == $past(wdata))
		else $error("carrier byte not written");

	a_shared_route: assert property (@(posedge mclk) disable iff (rst)
		((wr || rd) && shared_hit) |=>
			page_fsk == !($past(modem_family_select) && !$past(shared_page_access)))
		else $error("shared range routed to wrong page");

	a_page_pulse: assert property (@(posedge mclk) disable iff (rst)
		(wr && ext_hit) |=> page_wr ##1 !page_wr || $past(wr && ext_hit))
		else $error("forwarded write pulse wrong");

	a_page_read_pulse: assert property (@(posedge mclk) disable iff (rst)
		(rd && ext_hit) |=> page_rd && (page_addr == $past(addr)))
		else $error("forwarded read pulse wrong");

	a_family_route: assert property (@(posedge mclk) disable iff (rst)
		((wr || rd) && ext_hit && !shared_hit) |=> page_fsk == !$past(modem_family_select))
		else $error("page routed against the modem family");

	a_state_pulse: assert property (@(posedge mclk) disable iff (rst)
		!op_wr |=> !state_change)
		else $error("state change pulse without a mode write");

	a_band_select_write: assert property (@(posedge mclk) disable iff (rst)
		op_wr |=> band_page_select == $past(wdata[BAND_BIT]))
		else $error("band select not written");

endmodule

//--- hw/opmode_pkg.sv
// Purpose: Shared constants and types for the long-range operating-mode register page
// Assumes: 7-bit register address space, 8-bit register data
// Notes:   Band-page reset tables are held as functions so both copies stay in one place
package opmode_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [6:0] ADDR_FIFO         = 7'h00;
	localparam logic [6:0] ADDR_OPMODE       = 7'h01;
	localparam logic [6:0] ADDR_RSVD_LO      = 7'h02;
	localparam logic [6:0] ADDR_RSVD_HI      = 7'h05;
	localparam logic [6:0] ADDR_CARRIER_HIGH = 7'h06;
	localparam logic [6:0] ADDR_EXT_LO       = 7'h07;
	localparam logic [6:0] ADDR_SHARED_LO    = 7'h0D;
	localparam logic [6:0] ADDR_SHARED_HI    = 7'h3F;
	localparam logic [6:0] ADDR_EXT_HI       = 7'h60;
	localparam logic [6:0] ADDR_BAND_LO      = 7'h61;
	localparam logic [6:0] ADDR_BAND_HI      = 7'h73;
	localparam int         BAND_REGS         = 19;

	// ==========================================================
	// Operating-mode field positions
	localparam int FAMILY_BIT = 7;
	localparam int SHARED_BIT = 6;
	localparam int BAND_BIT   = 3;
	localparam int MODE_MSB   = 2;

	// ==========================================================
	// Values after reset
	localparam logic       FAMILY_RST       = 1'b0;
	localparam logic       SHARED_RST       = 1'b0;
	localparam logic       BAND_RST         = 1'b1;
	localparam logic [7:0] CARRIER_HIGH_RST = 8'h6C;
	localparam logic [7:0] DATA_RST         = 8'h00;

	// ==========================================================
	// Device states
	typedef enum logic [2:0] {
		sleep_state                = 3'b000,
		standby_state              = 3'b001,
		transmit_synthesis_state   = 3'b010,
		transmit_state             = 3'b011,
		receive_synthesis_state    = 3'b100,
		continuous_receive_state   = 3'b101,
		single_receive_state       = 3'b110,
		channel_activity_detection = 3'b111
	} device_state_e;

	localparam device_state_e MODE_RST = standby_state;

	// Low-band copy reset values, by index from the first band address
	function automatic logic [7:0] band_low_reset(input int idx);
		case (idx)
			0:       band_low_reset = 8'h19;
			1:       band_low_reset = 8'h0C;
			2:       band_low_reset = 8'h4B;
			3:       band_low_reset = 8'hCC;
			15:      band_low_reset = 8'hD0;
			default: band_low_reset = 8'h00;
		endcase
	endfunction

	// High-band copy reset values
	function automatic logic [7:0] band_high_reset(input int idx);
		case (idx)
			0:       band_high_reset = 8'h1C;
			1:       band_high_reset = 8'h0E;
			2:       band_high_reset = 8'h5B;
			3:       band_high_reset = 8'hCC;
			15:      band_high_reset = 8'hD0;
			default: band_high_reset = 8'h00;
		endcase
	endfunction

	// Writable bits; unused top bits stay zero
	function automatic logic [7:0] band_write_mask(input int idx);
		case (idx)
			0:       band_write_mask = 8'h3F;
			1:       band_write_mask = 8'h1F;
			default: band_write_mask = 8'hFF;
		endcase
	endfunction

endpackage

//--- hw/page_if.sv
// Purpose: Carriers between the register page and its FIFO memory and band bank
// Assumes: Single clock domain
// Notes:   Two small interfaces kept together since they serve one top module
`timescale 1ns/1ps

// ==========================================================
// FIFO memory port
interface fifo_if #(parameter int AW = 8, parameter int DW = 8);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport ctrl (output we, waddr, wdata, raddr, input rdata);
	modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

// ==========================================================
// Band register bank port
interface bank_if;
	logic       band_low;
	logic       we;
	logic [4:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl (output band_low, we, idx, wdata, input rdata);
	modport bank (input band_low, we, idx, wdata, output rdata);
endinterface

//--- sim/long_range_opmode_register_page_bench.sv
// Purpose: Self-checking bench for the long-range operating-mode register page
// Assumes: Register port with one-cycle strobes, read data in the cycle after rd
// Notes:   FIFO depth is cut to 4 so that full and empty are both reached quickly
`timescale 1ns/1ps
module long_range_opmode_register_page_bench;
	import opmode_pkg::*;

	// ==========================================================
	// Signals
	localparam int DEPTH = 4;
	logic          mclk;
	logic          rst;
	logic [6:0]    addr;
	logic [7:0]    wdata;
	logic          wr;
	logic          rd;
	logic [7:0]    rdata;
	logic          modem_family_select;
	logic          shared_page_access;
	logic          band_page_select;
	device_state_e device_state;
	logic          state_change;
	logic [7:0]    carrier_freq_high;
	logic          page_wr;
	logic          page_rd;
	logic          page_fsk;
	logic [6:0]    page_addr;
	logic [7:0]    page_wdata;
	int            err_total;
	int            n_compared;
	logic          sc;
	logic          pw;
	logic          pf;
	logic [6:0]    pa;

	long_range_opmode_register_page #(.FIFO_DEPTH(DEPTH)) u_dut (
		.mclk                (mclk),
		.rst                 (rst),
		.addr                (addr),
		.wdata               (wdata),
		.wr                  (wr),
		.rd                  (rd),
		.rdata               (rdata),
		.modem_family_select (modem_family_select),
		.shared_page_access  (shared_page_access),
		.band_page_select    (band_page_select),
		.device_state        (device_state),
		.state_change        (state_change),
		.carrier_freq_high   (carrier_freq_high),
		.page_wr             (page_wr),
		.page_rd             (page_rd),
		.page_fsk            (page_fsk),
		.page_addr           (page_addr),
		.page_wdata          (page_wdata)
	);

	// ==========================================================
	// Clock, 20 ns period
	initial mclk = 1'b0;
	always #10 mclk = ~mclk;

	// ==========================================================
	// Comparison and closing
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d, mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Bus tasks; pulse outputs are captured mid-cycle after the strobe edge
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
		@(negedge mclk);
		sc = state_change;
		pw = page_wr;
		pf = page_fsk;
		pa = page_addr;
	endtask

	task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
		@(posedge mclk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		check(rdata, exp);
	endtask

	// ==========================================================
	// Watchdog; the tests need well under 2000 cycles
	initial begin
		#(20 * 5000);
		err_total++;
		$display("unexpected at %0t: run did not finish", $time);
		give_verdict();
	end

	// ==========================================================
	// Tests
	initial begin
		err_total  = 0;
		n_compared = 0;
		rst   = 1'b1;
		addr  = 7'h00;
		wdata = 8'h00;
		wr    = 1'b0;
		rd    = 1'b0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;

		// Values after reset
		rd_reg(ADDR_OPMODE, 8'h09);
		rd_reg(ADDR_CARRIER_HIGH, 8'h6C);
		rd_reg(ADDR_FIFO, 8'h00);
		check({7'h00, band_page_select}, 8'h01);
		$display("test reset values done");

		// Family bit only moves from sleep
		wr_reg(ADDR_OPMODE, 8'h89);
		check({7'h00, sc}, 8'h01);
		rd_reg(ADDR_OPMODE, 8'h09);
		wr_reg(ADDR_OPMODE, 8'h08);
		check({5'h00, device_state}, 8'h00);
		wr_reg(ADDR_OPMODE, 8'h89);
		rd_reg(ADDR_OPMODE, 8'h89);
		wr_reg(ADDR_OPMODE, 8'h39);
		rd_reg(ADDR_OPMODE, 8'h89);
		check({7'h00, modem_family_select}, 8'h01);
		$display("test family lock done");

		// Every device state code, written and read back
		for (int i = 0; i < 8; i++) begin
			wr_reg(ADDR_OPMODE, {5'b10001, i[2:0]});
			check({5'h00, device_state}, {5'h00, i[2:0]});
			check({7'h00, sc}, 8'h01);
			rd_reg(ADDR_OPMODE, {5'b10001, i[2:0]});
		end
		$display("test state codes done");

		// FIFO order, full refusal, empty read, sleep flush and lock
		wr_reg(ADDR_OPMODE, 8'h89);
		for (int i = 0; i <= DEPTH; i++) begin
			wr_reg(ADDR_FIFO, 8'h10 + 8'(i));
		end
		for (int i = 0; i < DEPTH; i++) begin
			rd_reg(ADDR_FIFO, 8'h10 + 8'(i));
		end
		rd_reg(ADDR_FIFO, 8'h00);
		wr_reg(ADDR_FIFO, 8'h55);
		wr_reg(ADDR_OPMODE, 8'h88);
		rd_reg(ADDR_FIFO, 8'h00);
		wr_reg(ADDR_FIFO, 8'h66);
		wr_reg(ADDR_OPMODE, 8'h89);
		rd_reg(ADDR_FIFO, 8'h00);
		// Write then read with no gap between the strobes
		@(posedge mclk);
		wr    <= 1'b1;
		addr  <= ADDR_FIFO;
		wdata <= 8'h77;
		@(posedge mclk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		check(rdata, 8'h77);
		$display("test fifo done");

		// Carrier byte and reserved places
		wr_reg(ADDR_CARRIER_HIGH, 8'h5A);
		rd_reg(ADDR_CARRIER_HIGH, 8'h5A);
		check(carrier_freq_high, 8'h5A);
		for (int a = 2; a <= 5; a++) begin
			wr_reg(7'(a), 8'hFF);
			rd_reg(7'(a), 8'h00);
		end
		$display("test carrier and reserved done");

		// Page routing of the shared range and of the forwarded space outside it
		wr_reg(7'h20, 8'hA1);
		check({7'h00, pw}, 8'h01);
		check({1'b0, pa}, 8'h20);
		check({7'h00, pf}, 8'h00);
		wr_reg(ADDR_OPMODE, 8'hC9);
		check({7'h00, shared_page_access}, 8'h01);
		wr_reg(7'h3F, 8'hA2);
		check({7'h00, pf}, 8'h01);
		wr_reg(7'h0D, 8'hA3);
		check({7'h00, pf}, 8'h01);
		wr_reg(7'h40, 8'hA4);
		check({7'h00, pf}, 8'h00);
		wr_reg(ADDR_OPMODE, 8'h89);
		wr_reg(7'h0D, 8'hA5);
		check({7'h00, pf}, 8'h00);
		wr_reg(ADDR_OPMODE, 8'h88);
		wr_reg(ADDR_OPMODE, 8'h09);
		check({7'h00, modem_family_select}, 8'h00);
		wr_reg(7'h20, 8'hA6);
		check({7'h00, pf}, 8'h01);
		wr_reg(7'h40, 8'hA7);
		check({7'h00, pf}, 8'h01);
		check(page_wdata, 8'hA7);
		rd_reg(7'h40, 8'h00);
		check({7'h00, page_rd}, 8'h01);
		$display("test page routing done");

		// Band copies are separate and kept across switches
		rd_reg(ADDR_BAND_LO, 8'h19);
		wr_reg(ADDR_OPMODE, 8'h01);
		check({7'h00, band_page_select}, 8'h00);
		rd_reg(ADDR_BAND_LO, 8'h1C);
		wr_reg(ADDR_BAND_LO, 8'hFF);
		wr_reg(ADDR_BAND_HI, 8'h77);
		rd_reg(ADDR_BAND_LO, 8'h3F);
		wr_reg(ADDR_OPMODE, 8'h09);
		rd_reg(ADDR_BAND_LO, 8'h19);
		rd_reg(ADDR_BAND_HI, 8'h00);
		wr_reg(7'h62, 8'hFF);
		rd_reg(7'h62, 8'h1F);
		wr_reg(ADDR_OPMODE, 8'h01);
		rd_reg(ADDR_BAND_LO, 8'h3F);
		rd_reg(ADDR_BAND_HI, 8'h77);
		rd_reg(7'h62, 8'h0E);
		$display("test band copies done");

		give_verdict();
	end
endmodule
